// File: hw/dpot_pkg.sv
// constants, opcodes and state codes for the two-wire potentiometer slave
package dpot_pkg;

  // timing
  localparam int MCLK_PERIOD_NS = 50;
  localparam int WRITE_CYCLE_NS = 5_000_000;
  localparam int WRITE_CYCLE_CYCLES = WRITE_CYCLE_NS / MCLK_PERIOD_NS;

  // sizes
  localparam int WIPER_WIDTH = 8;
  localparam int TAP_COUNT = 256;
  localparam int PRESET_COUNT = 16;
  localparam int PRESET_IDX_WIDTH = 4;
  localparam int STRAP_WIDTH = 3;

  // reset values
  localparam logic [7:0] WIPER_RESET = 8'h00;
  localparam logic [7:0] PRESET_RESET = 8'h00;

  // device type code; value is arbitrary
  localparam logic [3:0] DEVICE_TYPE_ID = 4'ha;

  // slave address byte fields
  localparam int ID_MSB = 7;
  localparam int ID_LSB = 4;
  localparam int STRAP_MSB = 2;
  localparam int STRAP_LSB = 0;

  // instruction byte fields
  localparam int OP_MSB = 7;
  localparam int OP_LSB = 4;
  localparam int REG_MSB = 3;
  localparam int REG_LSB = 2;
  localparam int BANK_MSB = 1;
  localparam int BANK_LSB = 0;
  localparam logic [1:0] BANK_ZERO = 2'h0;

  // opcodes
  localparam logic [3:0] OP_READ_WIPER = 4'h9;
  localparam logic [3:0] OP_WRITE_WIPER = 4'ha;
  localparam logic [3:0] OP_READ_PRESET = 4'hb;
  localparam logic [3:0] OP_WRITE_PRESET = 4'hc;
  localparam logic [3:0] OP_PRESET_TO_WIPER = 4'hd;
  localparam logic [3:0] OP_WIPER_TO_PRESET = 4'he;
  localparam logic [3:0] OP_STEP_WIPER = 4'h2;

  // byte positions within a frame
  localparam logic [1:0] BYTE_ADDR = 2'h0;
  localparam logic [1:0] BYTE_INSTR = 2'h1;
  localparam logic [1:0] BYTE_DATA = 2'h2;
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_RX = 6'b000010,
    ST_ACK = 6'b000100,
    ST_TX = 6'b001000,
    ST_MACK = 6'b010000,
    ST_STEP = 6'b100000
  } state_type;

endpackage

// File: hw/tap_decoder.sv
// one-hot decoder of the wiper position onto the tap switches
`timescale 1ns/1ns
module tap_decoder #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // position in, switch enables out
  input wire logic [WIDTH-1:0] position,
  output logic [(2**WIDTH)-1:0] tap_select
);

  genvar i;
  generate
    for (i = 0; i < 2**WIDTH; i++) begin : g_tap
      // all switches open in reset; exactly one closed afterwards
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          tap_select[i] <= 1'b0;
        end else begin
          tap_select[i] <= (position == WIDTH'(i));
        end
      end
    end
  endgenerate

endmodule

// File: hw/dpot_slave.sv
// two-wire slave, wiper position and preset store of the potentiometer
//
// Contract
// - serial bits are sampled on the rising edge of the bus clock.
// - transmitted bits change only just after a falling bus clock edge.
// - data line is open drain: pull low or release, never drive high.
// - low three bits of the slave address come from the strap pins.
// - transaction proceeds only when received address bits equal the straps.
// - write protect low blocks every nonvolatile preset write.
// - wiper position is decoded onto one of 256 tap switches.
// - never more than one tap switch closed at a time.
// - at power-up the wiper is loaded from the default preset slot.
// - all sixteen presets, in any bank, the master can write and read directly.
// - data changes only while clock low; changes while high are start/stop.
// - start is data falling while clock high, before every command.
// - both lines are watched always; nothing happens before a start.
// - transmitter releases the data line after eight bits.
// - receiver pulls data low during the ninth clock to acknowledge.
// - acknowledge matching address, command byte and each data byte.
// - after a nonvolatile write stop, busy about 5 ms; address not acked.
// - upper four address bits must equal the fixed device type code.
// - sixteen presets in four banks; wiper transfers only with bank zero.
// - wiper changes only by write, preset load, step or power-up recall.
`timescale 1ns/1ns
module dpot_slave #(
  parameter int WRITE_CYCLE_CYCLES = dpot_pkg::WRITE_CYCLE_CYCLES
) (
  // clock and power-up reset
  input wire logic mclk,
  input wire logic reset_n,
  // two-wire bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // straps and write protect
  input wire logic [dpot_pkg::STRAP_WIDTH-1:0] addr_strap_pins,
  input wire logic write_protect_n,
  // potentiometer side
  output logic [dpot_pkg::WIPER_WIDTH-1:0] wiper_position_reg,
  output logic [dpot_pkg::TAP_COUNT-1:0] tap_select,
  output logic write_busy
);

  localparam int BUSY_W = $clog2(WRITE_CYCLE_CYCLES + 1);

  // synchronisers
  logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
  logic [dpot_pkg::STRAP_WIDTH-1:0] strap_m_q, strap_s_q;
  logic wp_m_q, wp_s_q;

  // serial engine
  dpot_pkg::state_type state_q;
  logic [1:0] byte_idx_q;
  logic [2:0] bit_cnt_q;
  logic full_q;
  logic [7:0] rx_q, tx_q, instr_q;
  logic mack_q, sda_oe_q, sda_out_q;

  // storage
  logic [7:0] wiper_q, nv_val_q;
  logic recall_q, nv_pend_q, write_busy_q;
  logic [7:0] preset_q [dpot_pkg::PRESET_COUNT];
  logic [dpot_pkg::PRESET_IDX_WIDTH-1:0] nv_idx_q;
  logic [BUSY_W-1:0] busy_cnt_q;

  // bus events and decodes
  logic scl_rise, scl_fall, bus_start, bus_stop;
  logic byte_end, addr_ok, instr_end, data_end, ack_fall;
  logic [3:0] rx_op, cur_op;
  logic [dpot_pkg::PRESET_IDX_WIDTH-1:0] rx_idx, cur_idx;
  logic rx_bank0;
  logic [7:0] read_value;
  logic to_tx, to_step;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
      strap_m_q <= '0;
      strap_s_q <= '0;
      wp_m_q <= 1'b0;
      wp_s_q <= 1'b0;
    end else begin
      scl_m_q <= scl_in;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= sda_in;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
      strap_m_q <= addr_strap_pins;
      strap_s_q <= strap_m_q;
      wp_m_q <= write_protect_n;
      wp_s_q <= wp_m_q;
    end
  end

  // edges of the bus lines, seen on mclk
  assign scl_rise = scl_s_q & ~scl_p_q;
  assign scl_fall = ~scl_s_q & scl_p_q;
  // data edges while clock high are framing only
  assign bus_start = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign bus_stop = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

  assign byte_end = (state_q == dpot_pkg::ST_RX) && scl_fall && full_q;
  assign addr_ok = (rx_q[dpot_pkg::ID_MSB:dpot_pkg::ID_LSB] == dpot_pkg::DEVICE_TYPE_ID)
    && (rx_q[dpot_pkg::STRAP_MSB:dpot_pkg::STRAP_LSB] == strap_s_q)
    && !write_busy_q;
  assign instr_end = byte_end && (byte_idx_q == dpot_pkg::BYTE_INSTR);
  assign data_end = byte_end && (byte_idx_q == dpot_pkg::BYTE_DATA);
  assign ack_fall = (state_q == dpot_pkg::ST_ACK) && scl_fall;

  // register pointer is bank then register
  assign rx_op = rx_q[dpot_pkg::OP_MSB:dpot_pkg::OP_LSB];
  assign rx_idx = {rx_q[dpot_pkg::BANK_MSB:dpot_pkg::BANK_LSB],
                   rx_q[dpot_pkg::REG_MSB:dpot_pkg::REG_LSB]};
  assign rx_bank0 = (rx_q[dpot_pkg::BANK_MSB:dpot_pkg::BANK_LSB] == dpot_pkg::BANK_ZERO);
  assign cur_op = instr_q[dpot_pkg::OP_MSB:dpot_pkg::OP_LSB];
  assign cur_idx = {instr_q[dpot_pkg::BANK_MSB:dpot_pkg::BANK_LSB],
                    instr_q[dpot_pkg::REG_MSB:dpot_pkg::REG_LSB]};

  assign read_value = (cur_op == dpot_pkg::OP_READ_WIPER) ? wiper_q : preset_q[cur_idx];
  assign to_tx = (byte_idx_q == dpot_pkg::BYTE_INSTR)
    && ((cur_op == dpot_pkg::OP_READ_WIPER) || (cur_op == dpot_pkg::OP_READ_PRESET));
  assign to_step = (byte_idx_q == dpot_pkg::BYTE_INSTR) && (cur_op == dpot_pkg::OP_STEP_WIPER);

  // frame sequencer
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= dpot_pkg::ST_IDLE;
    end else if (bus_start) begin
      state_q <= dpot_pkg::ST_RX;
    end else if (bus_stop) begin
      state_q <= dpot_pkg::ST_IDLE;
    end else begin
      unique case (state_q)
        dpot_pkg::ST_IDLE, dpot_pkg::ST_STEP: begin
          state_q <= state_q;
        end
        dpot_pkg::ST_RX: begin
          if (byte_end) begin
            if (byte_idx_q == dpot_pkg::BYTE_ADDR && !addr_ok) begin
              state_q <= dpot_pkg::ST_IDLE;
            end else begin
              state_q <= dpot_pkg::ST_ACK;
            end
          end
        end
        dpot_pkg::ST_ACK: begin
          if (scl_fall) begin
            if (to_tx) begin
              state_q <= dpot_pkg::ST_TX;
            end else if (to_step) begin
              state_q <= dpot_pkg::ST_STEP;
            end else begin
              state_q <= dpot_pkg::ST_RX;
            end
          end
        end
        dpot_pkg::ST_TX: begin
          if (scl_fall && bit_cnt_q == dpot_pkg::LAST_BIT) begin
            state_q <= dpot_pkg::ST_MACK;
          end
        end
        dpot_pkg::ST_MACK: begin
          if (scl_fall) begin
            state_q <= mack_q ? dpot_pkg::ST_TX : dpot_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= dpot_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // byte position in the frame
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      byte_idx_q <= dpot_pkg::BYTE_ADDR;
    end else if (bus_start) begin
      byte_idx_q <= dpot_pkg::BYTE_ADDR;
    end else if (ack_fall && byte_idx_q != dpot_pkg::BYTE_DATA) begin
      byte_idx_q <= byte_idx_q + 2'h1;
    end
  end

  // bit counter and byte-complete flag
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      bit_cnt_q <= 3'h0;
      full_q <= 1'b0;
    end else if (bus_start || bus_stop) begin
      bit_cnt_q <= 3'h0;
      full_q <= 1'b0;
    end else if (state_q == dpot_pkg::ST_RX && scl_rise) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      full_q <= (bit_cnt_q == dpot_pkg::LAST_BIT);
    end else if (state_q == dpot_pkg::ST_TX && scl_fall) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
    end else if (scl_fall) begin
      full_q <= 1'b0;
      if (state_q == dpot_pkg::ST_ACK || state_q == dpot_pkg::ST_MACK) begin
        bit_cnt_q <= 3'h0;
      end
    end
  end

  // receive shifter, msb first
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rx_q <= 8'h00;
    end else if (state_q == dpot_pkg::ST_RX && scl_rise) begin
      rx_q <= {rx_q[6:0], sda_s_q};
    end
  end

  // instruction latch
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      instr_q <= 8'h00;
    end else if (instr_end) begin
      instr_q <= rx_q;
    end
  end

  // master acknowledge after a read byte
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mack_q <= 1'b0;
    end else if (state_q == dpot_pkg::ST_MACK && scl_rise) begin
      mack_q <= ~sda_s_q;
    end
  end

  // transmit shifter, advanced on clock falls
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tx_q <= 8'h00;
    end else if (ack_fall && to_tx) begin
      tx_q <= read_value;
    end else if (state_q == dpot_pkg::ST_TX && scl_fall) begin
      tx_q <= {tx_q[6:0], 1'b0};
    end else if (state_q == dpot_pkg::ST_MACK && scl_fall && mack_q) begin
      tx_q <= read_value;
    end
  end

  // open-drain data driver: enable means pull low
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sda_oe_q <= 1'b0;
      sda_out_q <= 1'b0;
    end else begin
      sda_out_q <= 1'b0;
      if (bus_start || bus_stop) begin
        sda_oe_q <= 1'b0;
      end else if (byte_end) begin
        sda_oe_q <= (byte_idx_q != dpot_pkg::BYTE_ADDR) || addr_ok;
      end else if (ack_fall) begin
        sda_oe_q <= to_tx ? ~read_value[7] : 1'b0;
      end else if (state_q == dpot_pkg::ST_TX && scl_fall) begin
        if (bit_cnt_q == dpot_pkg::LAST_BIT) begin
          sda_oe_q <= 1'b0;
        end else begin
          sda_oe_q <= ~tx_q[6];
        end
      end else if (state_q == dpot_pkg::ST_MACK && scl_fall) begin
        sda_oe_q <= mack_q ? ~read_value[7] : 1'b0;
      end
    end
  end

  // power-up recall request
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      recall_q <= 1'b1;
    end else begin
      recall_q <= 1'b0;
    end
  end

  // wiper position
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wiper_q <= dpot_pkg::WIPER_RESET;
    end else if (recall_q) begin
      wiper_q <= preset_q[0];
    end else if (instr_end && rx_op == dpot_pkg::OP_PRESET_TO_WIPER && rx_bank0) begin
      wiper_q <= preset_q[rx_idx];
    end else if (data_end && cur_op == dpot_pkg::OP_WRITE_WIPER) begin
      wiper_q <= rx_q;
    end else if (state_q == dpot_pkg::ST_STEP && scl_rise) begin
      if (sda_s_q && wiper_q != 8'hff) begin
        wiper_q <= wiper_q + 8'h01;
      end else if (!sda_s_q && wiper_q != 8'h00) begin
        wiper_q <= wiper_q - 8'h01;
      end
    end
  end

  // nonvolatile write held until the closing stop
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      nv_pend_q <= 1'b0;
      nv_idx_q <= '0;
      nv_val_q <= 8'h00;
    end else if (bus_start || bus_stop) begin
      nv_pend_q <= 1'b0;
    end else if (data_end && cur_op == dpot_pkg::OP_WRITE_PRESET) begin
      nv_pend_q <= 1'b1;
      nv_idx_q <= cur_idx;
      nv_val_q <= rx_q;
    end else if (instr_end && rx_op == dpot_pkg::OP_WIPER_TO_PRESET && rx_bank0) begin
      nv_pend_q <= 1'b1;
      nv_idx_q <= rx_idx;
      nv_val_q <= wiper_q;
    end
  end

  // preset store
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int k = 0; k < dpot_pkg::PRESET_COUNT; k++) begin
        preset_q[k] <= dpot_pkg::PRESET_RESET;
      end
    end else if (bus_stop && nv_pend_q && wp_s_q) begin
      preset_q[nv_idx_q] <= nv_val_q;
    end
  end

  // internal write cycle timer
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      busy_cnt_q <= '0;
      write_busy_q <= 1'b0;
    end else begin
      if (bus_stop && nv_pend_q && wp_s_q) begin
        busy_cnt_q <= BUSY_W'(WRITE_CYCLE_CYCLES);
      end else if (busy_cnt_q != '0) begin
        busy_cnt_q <= busy_cnt_q - BUSY_W'(1);
      end
      write_busy_q <= (bus_stop && nv_pend_q && wp_s_q) || (busy_cnt_q > BUSY_W'(1));
    end
  end

  tap_decoder #(.WIDTH(dpot_pkg::WIPER_WIDTH)) u_taps (
    .mclk(mclk),
    .reset_n(reset_n),
    .position(wiper_q),
    .tap_select(tap_select)
  );

  assign sda_out = sda_out_q;
  assign sda_oe = sda_oe_q;
  assign wiper_position_reg = wiper_q;
  assign write_busy = write_busy_q;

endmodule

// File: testbench/dpot_slave_props.sv
// concurrent checks on the potentiometer slave ports
`timescale 1ns/1ns
module dpot_slave_props #(
  parameter int WRITE_CYCLE_CYCLES = 20
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // two-wire bus
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // potentiometer side
  input wire logic [dpot_pkg::WIPER_WIDTH-1:0] wiper_position_reg,
  input wire logic [dpot_pkg::TAP_COUNT-1:0] tap_select,
  input wire logic write_busy
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);

  int busy_cnt_q;
  logic active_q;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      busy_cnt_q <= 0;
    end else begin
      busy_cnt_q <= write_busy ? busy_cnt_q + 1 : 0;
    end
  end

  // frame open between start and stop on the raw lines
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      active_q <= 1'b0;
    end else if (scl_in && $fell(sda_in)) begin
      active_q <= 1'b1;
    end else if (scl_in && $rose(sda_in)) begin
      active_q <= 1'b0;
    end
  end

  sequence s_held;
    sda_oe [*7];
  endsequence

  property p_drain;
    sda_oe |-> !sda_out;
  endproperty
  property p_onehot;
    $onehot0(tap_select);
  endproperty
  property p_tap;
    $past(reset_n) |-> tap_select == (256'h1 << $past(wiper_position_reg));
  endproperty
  property p_busy_quiet;
    write_busy |-> !sda_oe;
  endproperty
  property p_busy_len;
    $fell(write_busy) |->
      busy_cnt_q >= WRITE_CYCLE_CYCLES - 2 && busy_cnt_q <= WRITE_CYCLE_CYCLES + 1;
  endproperty
  property p_edge;
    $changed(sda_oe) |-> !$past(scl_in);
  endproperty
  property p_held;
    $rose(sda_oe) |-> s_held;
  endproperty
  property p_idle;
    !active_q |-> !sda_oe;
  endproperty

  a_drain: assert property (p_drain) else $error("data line driven high");
  a_onehot: assert property (p_onehot) else $error("several taps closed");
  a_tap: assert property (p_tap) else $error("tap select not decoded");
  a_busy_quiet: assert property (p_busy_quiet) else $error("pull while busy");
  a_busy_len: assert property (p_busy_len) else $error("write cycle length");
  a_edge: assert property (p_edge) else $error("data moved with clock high");
  a_held: assert property (p_held) else $error("pull not held a clock");
  a_idle: assert property (p_idle) else $error("pull outside a frame");
endmodule

bind dpot_slave dpot_slave_props #(
  .WRITE_CYCLE_CYCLES(WRITE_CYCLE_CYCLES)
) dpot_slave_props_inst (
  .mclk(mclk), .reset_n(reset_n), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .wiper_position_reg(wiper_position_reg),
  .tap_select(tap_select), .write_busy(write_busy)
);

// File: testbench/two_wire_master.sv
// two-wire bus master model driving the bus clock and pulling the data line
`timescale 1ns/1ns
module two_wire_master (
  // system clock and resolved data wire
  input wire logic mclk,
  input wire logic sda_wire,
  // bus clock and data pull-down
  output logic scl,
  output logic pull
);
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // data falls while clock high
  task automatic start();
    pull = 1'b0;
    scl = 1'b1;
    tick(4);
    pull = 1'b1;
    tick(4);
    scl = 1'b0;
    tick(4);
  endtask

  // data rises while clock high
  task automatic stop();
    pull = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(4);
    pull = 1'b0;
    tick(4);
  endtask

  // one 400 ns bus clock, data changed only while low
  task automatic bit_io(input logic b, output logic r);
    pull = !b;
    tick(5);
    scl = 1'b1;
    tick(3);
    r = sda_wire;
    scl = 1'b0;
  endtask

  // eight bits then the ninth clock; last high releases the line
  task automatic xbyte(input logic [7:0] d, input logic last, output logic [7:0] r,
                       output logic a);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
    bit_io(last, a);
  endtask
endmodule

// File: testbench/tb_dpot_slave.sv
// self-checking bench for the potentiometer two-wire slave
`timescale 1ns/1ns
module tb_dpot_slave;
  localparam int WCC = 200;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [2:0] strap = 3'h0;
  logic wp_n = 1'b1;
  logic scl, pull, sda_oe, sda_out, busy, sda_wire, ack;
  logic [7:0] wiper, rd, e, q;
  logic [7:0] p [4];
  logic [255:0] taps;
  int err_count = 0;
  int checks_done = 0;

  always #25 mclk = ~mclk;
  // open drain wire with pull-up
  assign sda_wire = !((sda_oe && !sda_out) || pull);

  dpot_slave #(.WRITE_CYCLE_CYCLES(WCC)) dpot_slave_inst (
    .mclk(mclk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_strap_pins(strap), .write_protect_n(wp_n),
    .wiper_position_reg(wiper), .tap_select(taps), .write_busy(busy));
  two_wire_master two_wire_master_inst (
    .mclk(mclk), .sda_wire(sda_wire), .scl(scl), .pull(pull));

  task automatic end_sim();
    if (err_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [255:0] seen, input logic [255:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [7:0] addr_of(input logic [2:0] s);
    return {dpot_pkg::DEVICE_TYPE_ID, 1'b0, s};
  endfunction

  task automatic xfer(input logic [7:0] d, input logic exp_ack);
    two_wire_master_inst.xbyte(d, 1'b1, rd, ack);
    chk("ack", ack, !exp_ack);
  endtask

  task automatic hdr(input logic [3:0] op, input logic [3:0] rb);
    two_wire_master_inst.start();
    xfer(addr_of(strap), 1'b1);
    xfer({op, rb}, 1'b1);
  endtask

  task automatic wr(input logic [3:0] op, input logic [3:0] rb, input logic [7:0] d);
    hdr(op, rb);
    xfer(d, 1'b1);
    two_wire_master_inst.stop();
  endtask

  task automatic rd_chk(input logic [3:0] op, input logic [3:0] rb, input logic [7:0] exp);
    hdr(op, rb);
    two_wire_master_inst.xbyte(8'hff, 1'b0, rd, ack);
    chk("read", rd, exp);
    two_wire_master_inst.xbyte(8'hff, 1'b1, rd, ack);
    chk("read_again", rd, exp);
    two_wire_master_inst.stop();
  endtask

  task automatic wait_idle();
    for (int n = 0; n < 8 && busy !== 1'b1; n++) begin
      @(negedge mclk);
    end
    for (int n = 0; n < 300 && busy !== 1'b0; n++) begin
      @(negedge mclk);
    end
    if (busy !== 1'b0) begin
      chk("busy_wait", 1'b1, 1'b0);
    end
  endtask

  initial begin
    e = 8'($urandom(9572));
    repeat (10) @(negedge mclk);
    reset_n = 1'b1;
    repeat (3) @(negedge mclk);
    chk("wiper_por", wiper, 8'h00);
    chk("tap_por", taps, 256'h1);
    for (int s = 0; s < 8; s++) begin
      strap = 3'(s);
      e = (s == 7) ? 8'hff : 8'($urandom);
      wr(dpot_pkg::OP_WRITE_WIPER, 4'h0, e);
      chk("wiper", wiper, e);
      chk("taps", taps, 256'h1 << e);
      rd_chk(dpot_pkg::OP_READ_WIPER, 4'h0, e);
    end
    // foreign strap, then foreign device type
    for (int i = 0; i < 2; i++) begin
      two_wire_master_inst.start();
      xfer(i == 0 ? addr_of(~strap) : {4'h3, 1'b0, strap}, 1'b0);
      xfer({dpot_pkg::OP_WRITE_WIPER, 4'h0}, 1'b0);
      xfer(8'h5a, 1'b0);
      two_wire_master_inst.stop();
      chk("wiper_kept", wiper, e);
    end
    hdr(dpot_pkg::OP_STEP_WIPER, 4'h0);
    for (int i = 3; i >= 0; i--) begin
      two_wire_master_inst.bit_io(i == 0 || i == 3, ack);
      e = (i == 0 || i == 3) ? (e == 8'hff ? e : e + 8'h01) : (e == 8'h00 ? e : e - 8'h01);
    end
    // the stop's own clock rises with data low: one more step down
    e = (e == 8'h00) ? e : e - 8'h01;
    two_wire_master_inst.stop();
    chk("step", wiper, e);
    hdr(dpot_pkg::OP_WRITE_WIPER, 4'h0);
    repeat (4) two_wire_master_inst.bit_io(1'b0, ack);
    two_wire_master_inst.stop();
    chk("abort", wiper, e);
    for (int r = 0; r < 4; r++) begin
      p[r] = 8'($urandom);
      wr(dpot_pkg::OP_WRITE_PRESET, 4'(r << 2), p[r]);
      two_wire_master_inst.start();
      xfer(addr_of(strap), 1'b0);
      two_wire_master_inst.stop();
      wait_idle();
      rd_chk(dpot_pkg::OP_READ_PRESET, 4'(r << 2), p[r]);
    end
    q = ~p[1];
    wr(dpot_pkg::OP_WRITE_PRESET, 4'h1, q);
    wait_idle();
    rd_chk(dpot_pkg::OP_READ_PRESET, 4'h1, q);
    wp_n = 1'b0;
    wr(dpot_pkg::OP_WRITE_PRESET, 4'h0, ~p[0]);
    wait_idle();
    rd_chk(dpot_pkg::OP_READ_PRESET, 4'h0, p[0]);
    wp_n = 1'b1;
    hdr(dpot_pkg::OP_PRESET_TO_WIPER, 4'h4);
    two_wire_master_inst.stop();
    chk("xfr", wiper, p[1]);
    hdr(dpot_pkg::OP_PRESET_TO_WIPER, 4'h1);
    two_wire_master_inst.stop();
    chk("xfr_bank", wiper, p[1]);
    hdr(dpot_pkg::OP_WIPER_TO_PRESET, 4'hc);
    two_wire_master_inst.stop();
    wait_idle();
    rd_chk(dpot_pkg::OP_READ_PRESET, 4'hc, p[1]);
    end_sim();
  end
endmodule
